// ===== core/xfer_timeout_pkg.sv
`default_nettype none
package xfer_timeout_pkg;
  // port-control page protocol identifier for parallel devices
  localparam logic [3:0]  PROTOCOL_ID_PARALLEL = 4'h1;
  localparam logic [15:0] TIMEOUT_DISABLED     = 16'h0000;
  localparam logic [15:0] TIMEOUT_UNLIMITED    = 16'hFFFF;
  localparam int          CLK_HZ               = 10_000_000;
  localparam int          TICK_MS              = 1;
  localparam int          TICK_CYCLES          = CLK_HZ / 1000 * TICK_MS;
  localparam int          OFFSET_W             = 8;

  typedef enum logic [1:0] {
    TMR_IDLE    = 2'b00,
    TMR_RUN     = 2'b01,
    TMR_EXPIRED = 2'b10
  } timer_state_e;

  typedef struct packed {
    logic req_edge;
    logic ack_edge;
  } bus_events_s;
endpackage : xfer_timeout_pkg
`default_nettype wire

// ===== core/ms_tick_gen.sv
`default_nettype none
module ms_tick_gen
  import xfer_timeout_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // restart aligns the tick to a freshly loaded count
  input  wire logic restart,
  output logic      tick
);
  initial begin
    if (TICK_DIV < 2) begin
      $error("ms_tick_gen: TICK_DIV must be at least 2");
    end
  end

  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg + 32'h0000_0001;
    if (restart || cnt_reg == 32'(TICK_DIV - 1)) begin
      cnt_next = 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= 32'h0000_0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign tick = !restart && (cnt_reg == 32'(TICK_DIV - 1));
endmodule : ms_tick_gen
`default_nettype wire

// ===== core/sync_transfer_timeout_timer.sv
// What this block does
// RULE1: reports protocol identifier one for parallel devices
// RULE2: timeout counted in one millisecond units
// RULE3: bus free only on unreloaded expiry
// RULE4: REQ with none outstanding loads and starts
// RULE5: REQ with some outstanding leaves timer alone
// RULE6: ACK with REQs outstanding reloads timer
// RULE7: ACK leaving none outstanding stops timer
// RULE8: zero setting disables timeout; an expiry already latched stays
// RULE9: all-ones setting means unlimited period
// RULE10: 16-bit setting, ms decrement, offset counter
`default_nettype none
module sync_transfer_timeout_timer
  import xfer_timeout_pkg::*;
#(
  parameter int TICK_DIV  = TICK_CYCLES,
  parameter int OFFSET_WD = OFFSET_W
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // bus pins, asynchronous to core_clk
  input  wire logic        req_pin,
  input  wire logic        ack_pin,
  // configuration and connection state
  input  wire logic [15:0] timeout_ms,
  input  wire logic        connected,
  // status
  output logic [3:0]       protocol_id,
  output logic             timer_running,
  output logic [OFFSET_WD-1:0] outstanding,
  output logic             force_bus_free
);
  initial begin
    if (OFFSET_WD < 1 || OFFSET_WD > 16) begin
      $error("sync_transfer_timeout_timer: OFFSET_WD out of range");
    end
    // the divider needs room for both a restart and a tick
    if (TICK_DIV < 2) begin
      $error("sync_transfer_timeout_timer: TICK_DIV below 2");
    end
  end

  localparam int                   SYNC_LINES = 2;
  localparam logic [OFFSET_WD-1:0] OFFS_ONE   = OFFSET_WD'(1);
  localparam logic [OFFSET_WD-1:0] OFFS_MAX   = '1;
  localparam logic [15:0]          COUNT_ONE  = 16'h0001;

  // zero switches the timer off; an expiry already latched is kept
  function automatic logic setting_disabled(input logic [15:0] v);
    return v == TIMEOUT_DISABLED;
  endfunction : setting_disabled

  // all ones: the period never runs out
  function automatic logic setting_unlimited(input logic [15:0] v);
    return v == TIMEOUT_UNLIMITED;
  endfunction : setting_unlimited

  // two synchroniser stages, a third for edge detection;
  // line 0 carries REQ, line 1 carries ACK
  logic [SYNC_LINES-1:0] pin_raw;
  logic [SYNC_LINES-1:0] pin_edge;
  assign pin_raw = {ack_pin, req_pin};

  for (genvar i = 0; i < SYNC_LINES; i++) begin : g_sync
    logic [2:0] stage_reg;
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        stage_reg <= 3'h0;
      end else begin
        stage_reg <= {stage_reg[1:0], pin_raw[i]};
      end
    end
    // stage 0 may be metastable, so only stages 1 and 2 are read
    assign pin_edge[i] = stage_reg[2] ^ stage_reg[1];
  end

  // each REQ or ACK transition (either edge) is one event
  bus_events_s ev;
  always_comb begin
    ev.req_edge = pin_edge[0];
    ev.ack_edge = pin_edge[1];
  end

  timer_state_e           state_reg;
  timer_state_e           state_next;
  logic [15:0]            count_reg;
  logic [15:0]            count_next;
  logic [OFFSET_WD-1:0]   offs_reg;
  logic [OFFSET_WD-1:0]   offs_next;
  logic                   load;
  logic                   tick;
  logic                   dec_due;
  logic                   running_reg;
  logic                   running_next;
  logic                   bus_free_reg;
  logic                   bus_free_next;
  logic [3:0]             proto_reg;

  // a new load restarts the divider so a full millisecond always elapses
  ms_tick_gen #(
    .TICK_DIV(TICK_DIV)
  ) u_tick (
    .core_clk(core_clk),
    .reset   (reset),
    .restart (load),
    .tick    (tick)
  );

  // outstanding REQ offset counter [RULE10]
  // saturates: a wrap would look like nothing outstanding
  always_comb begin
    offs_next = offs_reg;
    if (!connected) begin
      offs_next = '0;
    end else if (ev.req_edge && !ev.ack_edge && offs_reg != OFFS_MAX) begin
      offs_next = offs_reg + OFFS_ONE;
    end else if (ev.ack_edge && !ev.req_edge && offs_reg != '0) begin
      offs_next = offs_reg - OFFS_ONE;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      offs_reg <= '0;
    end else begin
      offs_reg <= offs_next;
    end
  end

  // unlimited never decrements [RULE9]
  assign dec_due = tick && !setting_unlimited(timeout_ms);

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    load       = 1'b0;
    if (!connected) begin
      state_next = TMR_IDLE;
    end else begin
      case (state_reg)
        TMR_IDLE, TMR_RUN: begin
          if (ev.req_edge && offs_reg == '0) begin
            load = 1'b1; // [RULE4]
          end else if (ev.ack_edge && offs_next != '0) begin
            load = 1'b1; // [RULE6]
          end else if (ev.ack_edge && offs_next == '0) begin
            state_next = TMR_IDLE; // [RULE7]
          end
          // ev.req_edge without ev.ack_edge, offs_reg nonzero: no change [RULE5]
          if (load) begin
            count_next = timeout_ms; // [RULE2]
            state_next = TMR_RUN;
          end else if (state_reg == TMR_RUN && state_next == TMR_RUN
                       && dec_due) begin
            if (count_reg <= COUNT_ONE) begin
              count_next = 16'h0000;
              state_next = TMR_EXPIRED; // [RULE3]
            end else begin
              count_next = count_reg - COUNT_ONE; // [RULE10]
            end
          end
          if (setting_disabled(timeout_ms)) begin
            state_next = TMR_IDLE; // [RULE8]
          end
        end
        TMR_EXPIRED: begin
          // held until the connection is dropped
          state_next = TMR_EXPIRED;
        end
        default: begin
          state_next = TMR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg <= TMR_IDLE;
      count_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // status held in its own flops so no decode glitch reaches a pin
  always_comb begin
    running_next  = (state_next == TMR_RUN);
    bus_free_next = (state_next == TMR_EXPIRED);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      running_reg  <= 1'b0;
      bus_free_reg <= 1'b0;
      proto_reg    <= PROTOCOL_ID_PARALLEL;
    end else begin
      running_reg  <= running_next;
      bus_free_reg <= bus_free_next;
      proto_reg    <= PROTOCOL_ID_PARALLEL; // [RULE1]
    end
  end

  assign protocol_id    = proto_reg; // [RULE1]
  assign timer_running  = running_reg;
  assign outstanding    = offs_reg;
  assign force_bus_free = bus_free_reg; // [RULE3]
endmodule : sync_transfer_timeout_timer
`default_nettype wire

// ===== sim/initiator_model.sv
`default_nettype none
module initiator_model (
  // clock
  input  wire logic core_clk,
  // one ack transition for each cycle go is seen high
  input  wire logic go,
  output logic      ack_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial ack_pin = 1'b0;
  // late by 5 ns so the edge never races the sampler
  always @(posedge core_clk) if (go) ack_pin <= #5 ~ack_pin;
endmodule : initiator_model
`default_nettype wire

// ===== sim/xfer_timeout_checker.sv
`default_nettype none
module xfer_timeout_checker #(
  parameter int TICK_DIV  = 4,
  parameter int OFFSET_WD = 8
) (
  input wire logic                 core_clk,
  input wire logic                 reset,
  input wire logic                 connected,
  input wire logic [15:0]          timeout_ms,
  input wire logic [3:0]           protocol_id,
  input wire logic                 timer_running,
  input wire logic [OFFSET_WD-1:0] outstanding,
  input wire logic                 force_bus_free
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_id_constant: assert property (protocol_id == 4'h1)
    else $error("protocol id wrong");
  a_no_early_expiry: assert property (
    $rose(timer_running) |-> !force_bus_free [*3])
    else $error("expiry too soon");
  a_expiry_stops_timer: assert property (
    $rose(force_bus_free) |-> $past(timer_running) && !timer_running)
    else $error("expiry without running timer");
  a_start_single_req: assert property (
    $rose(timer_running) |-> outstanding == 1)
    else $error("timer started with wrong offset");
  a_empty_stops_timer: assert property (
    outstanding == 0 |-> !timer_running)
    else $error("timer runs with no offset");
  a_zero_disables: assert property (
    timeout_ms == 16'h0000 |=> !timer_running && !force_bus_free)
    else $error("disabled timer active");
  a_unlimited_no_expiry: assert property (
    timeout_ms == 16'hFFFF && !force_bus_free |=> !force_bus_free)
    else $error("unlimited timer expired");
  a_offset_one_step: assert property (
    connected && $past(connected) |-> outstanding == $past(outstanding)
    || outstanding == $past(outstanding) + 1'b1
    || outstanding + 1'b1 == $past(outstanding))
    else $error("offset jumped");
endmodule : xfer_timeout_checker
bind sync_transfer_timeout_timer xfer_timeout_checker #(
  .TICK_DIV(TICK_DIV), .OFFSET_WD(OFFSET_WD)) chk (
  .core_clk(core_clk), .reset(reset), .connected(connected),
  .timeout_ms(timeout_ms), .protocol_id(protocol_id),
  .timer_running(timer_running), .outstanding(outstanding),
  .force_bus_free(force_bus_free));
`default_nettype wire

// ===== sim/sync_transfer_timeout_timer_bench.sv
`default_nettype none
module sync_transfer_timeout_timer_bench;
  import xfer_timeout_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, reset = 1, req_pin = 0, connected = 0, go = 0;
  logic [15:0] timeout_ms = 16'h0000;
  logic ack_pin, timer_running, force_bus_free;
  logic [3:0] protocol_id;
  logic [OFFSET_W-1:0] outstanding;
  int miscompares = 0, comparisons = 0, seed = 74, cyc = 0, n, t;
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin \
  miscompares++; $display("BAD %s exp %0h got %0h", nm, e, s); end end
  always #50 core_clk = ~core_clk;
  sync_transfer_timeout_timer #(.TICK_DIV(4)) dut (
    .core_clk(core_clk), .reset(reset), .req_pin(req_pin),
    .ack_pin(ack_pin), .timeout_ms(timeout_ms), .connected(connected),
    .protocol_id(protocol_id), .timer_running(timer_running),
    .outstanding(outstanding), .force_bus_free(force_bus_free));
  initiator_model peer (.core_clk(core_clk), .go(go), .ack_pin(ack_pin));
  task print_verdict;
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 5000) begin
      miscompares++;
      print_verdict();
    end
  end
  // cycles from the req toggle to expiry: sync, load, then ms ticks of 4
  function automatic int expiry_cycles(input int ms);
    return ms * 4 + 3;
  endfunction : expiry_cycles
  task tick(input int k);
    repeat (k) @(posedge core_clk);
    #5;
  endtask : tick
  task ack;
    go = 1;
    tick(1);
    go = 0;
  endtask : ack
  // fresh connection, then the first req transition
  task start(input logic [15:0] v);
    connected = 0;
    tick(2);
    timeout_ms = v;
    connected = 1;
    tick(1);
    req_pin = ~req_pin;
  endtask : start
  task expire;
    n = 0;
    while (force_bus_free !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
  endtask : expire
  initial begin
    tick(3);
    reset = 0;
    `CHK("id", PROTOCOL_ID_PARALLEL, protocol_id)
    repeat (4) begin
      t = 1 + {$random(seed)} % 8;
      start(t[15:0]);
      expire();
      `CHK("expiry", 1'b1, n >= expiry_cycles(t) && n <= expiry_cycles(t)+3)
    end
    start(16'h0004);
    tick(8);
    req_pin = ~req_pin;
    tick(5);
    `CHK("offset", 8'h02, outstanding)
    expire();
    `CHK("no reload", 1'b1, n >= 6 && n <= 9)
    start(16'h0004);
    tick(2);
    req_pin = ~req_pin;
    tick(8);
    ack();
    expire();
    `CHK("reload", 1'b1, n >= 19 && n <= 22)
    start(16'h0002);
    tick(6);
    ack();
    tick(6);
    `CHK("stopped", 1'b0, timer_running)
    tick(40);
    `CHK("no expiry", 1'b0, force_bus_free)
    start(TIMEOUT_UNLIMITED);
    tick(200);
    `CHK("unlimited", 2'b10, {timer_running, force_bus_free})
    start(TIMEOUT_DISABLED);
    tick(40);
    `CHK("disabled", 2'b00, {timer_running, force_bus_free})
    print_verdict();
  end
endmodule : sync_transfer_timeout_timer_bench
`default_nettype wire
